/* src/adc_seq_ctrl.sv */
// Power-mode, channel-selection and sequencer control of the converter
`timescale 1ns/1ps
module adc_seq_ctrl
  import adc_seq_pkg::*;
(
  input  wire logic clk_sys,          // System clock, 10 MHz
  input  wire logic rst,              // Reset, active high; synchronous here, asynchronous in the serial receiver
  input  wire logic sclk,             // Serial clock from the host
  input  wire logic cs_n,             // Chip select, active low
  input  wire logic din,              // Serial data in
  output logic      conv_start,       // One-cycle pulse per conversion
  output logic [2:0] conv_channel,    // Channel of the started conversion
  output logic      powered,          // Analog circuitry powered
  output logic      awake,            // Wake-up interval has elapsed
  output logic      range_single,     // 1: one times reference span
  output logic      coding_binary,    // 1: straight binary coding
  output logic [1:0] seq_mode         // Current sequencer mode
);

  logic [15:0] frame_word;
  logic        frame_toggle;

  serial_frame_rx u_rx (
    .sclk         (sclk),
    .rst          (rst),
    .cs_n         (cs_n),
    .din          (din),
    .frame_word   (frame_word),
    .frame_toggle (frame_toggle)
  );

  // Crossing into the system domain
  logic cs_sync1_r;
  logic cs_sync2_r;
  logic cs_prev_r;
  logic tog_sync1_r;
  logic tog_sync2_r;
  logic tog_prev_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cs_sync1_r  <= 1'b1;
      cs_sync2_r  <= 1'b1;
      cs_prev_r   <= 1'b1;
      tog_sync1_r <= 1'b0;
      tog_sync2_r <= 1'b0;
      tog_prev_r  <= 1'b0;
    end else begin
      cs_sync1_r  <= cs_n;
      cs_sync2_r  <= cs_sync1_r;
      cs_prev_r   <= cs_sync2_r;
      tog_sync1_r <= frame_toggle;
      tog_sync2_r <= tog_sync1_r;
      tog_prev_r  <= tog_sync2_r;
    end
  end

  logic cs_fall;
  logic frame_done;
  assign cs_fall    = cs_prev_r & ~cs_sync2_r;
  assign frame_done = tog_sync2_r ^ tog_prev_r;

  // Next occupied slot after cur, wrapping; slot s lives in mask bit ~s
  function automatic logic [3:0] next_slot(input logic [15:0] mask,
                                           input logic [3:0]  cur);
    logic [3:0] cand;
    logic [3:0] res;
    logic       found;
    res   = cur;
    found = 1'b0;
    cand  = cur;
    for (int i = 1; i <= FRAME_BITS; i++) begin
      cand = 4'(int'(cur) + i);
      if (!found && mask[~cand]) begin
        res   = cand;
        found = 1'b1;
      end
    end
    return res;
  endfunction : next_slot

  // Frame decode
  ctrl_word_type ctrl_r;
  ctrl_word_type new_ctrl;
  logic          mask_pending_r;
  logic          ctrl_load;
  logic          mask_load;
  logic [1:0]    new_seq_bits;

  assign new_ctrl     = ctrl_word_type'(frame_word[FRAME_WRITE_BIT-1:CTRL_LSB]);
  assign new_seq_bits = {new_ctrl.sequence_enable, new_ctrl.reg_select};
  assign mask_load    = frame_done & mask_pending_r;
  assign ctrl_load    = frame_done & ~mask_pending_r
                        & frame_word[FRAME_WRITE_BIT];

  // Control word is kept through every power mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_r <= ctrl_word_type'(CTRL_RESET);
    end else if (ctrl_load) begin
      ctrl_r <= new_ctrl;
    end
  end

  // A frame that carries the mask never counts as a control write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mask_pending_r <= 1'b0;
    end else if (frame_done) begin
      mask_pending_r <= ctrl_load && new_seq_bits == 2'b01;
    end
  end

  logic [15:0] mask_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mask_r <= MASK_RESET;
    end else if (mask_load) begin
      mask_r <= frame_word;
    end
  end

  // Sequencer
  seq_mode_type mode_r;
  logic [3:0]   slot_r;
  logic [3:0]   slot_nxt;
  logic [3:0]   first_slot;
  logic [2:0]   next_chan_r;
  logic [2:0]   final_chan_r;

  assign first_slot = next_slot(frame_word, SLOT_LAST);
  assign slot_nxt   = next_slot(mask_r, slot_r);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_r       <= SEQ_MANUAL;
      slot_r       <= 4'h0;
      next_chan_r  <= CHAN_RESET;
      final_chan_r <= CHAN_RESET;
    end else if (mask_load) begin
      mode_r      <= SEQ_MASKED;
      slot_r      <= first_slot;
      next_chan_r <= first_slot[2:0];
    end else if (ctrl_load) begin
      case (new_seq_bits)
        2'b00: begin
          mode_r      <= SEQ_MANUAL;
          next_chan_r <= new_ctrl.channel_addr;
        end
        2'b01: begin
          mode_r      <= SEQ_MANUAL;
          next_chan_r <= new_ctrl.channel_addr;
        end
        2'b10: begin
          // Sequence keeps running; only a manual channel follows
          if (mode_r == SEQ_MANUAL) begin
            next_chan_r <= new_ctrl.channel_addr;
          end
        end
        2'b11: begin
          mode_r       <= SEQ_CONSEC;
          final_chan_r <= new_ctrl.channel_addr;
          next_chan_r  <= CHAN_RESET;
        end
        default: begin
          mode_r <= SEQ_MANUAL;
        end
      endcase
    end else if (cs_fall) begin
      case (mode_r)
        SEQ_MASKED: begin
          slot_r      <= slot_nxt;
          next_chan_r <= slot_nxt[2:0];
        end
        SEQ_CONSEC: begin
          if (next_chan_r == final_chan_r) begin
            next_chan_r <= CHAN_RESET;
          end else begin
            next_chan_r <= next_chan_r + 3'h1;
          end
        end
        SEQ_MANUAL: begin
          next_chan_r <= next_chan_r;
        end
        default: begin
          mode_r <= SEQ_MANUAL;
        end
      endcase
    end
  end

  // Conversion start on each chip-select fall
  logic       conv_start_r;
  logic [2:0] conv_channel_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conv_start_r   <= 1'b0;
      conv_channel_r <= CHAN_RESET;
    end else begin
      conv_start_r <= cs_fall;
      if (cs_fall) begin
        conv_channel_r <= next_chan_r;
      end
    end
  end

  // Power management
  logic       powered_r;
  logic       awake_r;
  logic [3:0] wake_cnt_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      powered_r <= 1'b1;
    end else if (ctrl_load) begin
      case (new_ctrl.power_mode)
        PWR_NORMAL:   powered_r <= 1'b1;
        PWR_SHUTDOWN: powered_r <= 1'b0;
        PWR_AUTO:     powered_r <= 1'b0;
        PWR_INVALID:  powered_r <= powered_r;
        default:      powered_r <= powered_r;
      endcase
    end else if (cs_fall && ctrl_r.power_mode == PWR_AUTO) begin
      powered_r <= 1'b1;
    end
  end

  // Readiness flag only reports; conversions are never blocked by it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wake_cnt_r <= WAKE_CYCLES;
      awake_r    <= 1'b1;
    end else if (!powered_r) begin
      wake_cnt_r <= 4'h0;
      awake_r    <= 1'b0;
    end else begin
      if (wake_cnt_r != WAKE_CYCLES) begin
        wake_cnt_r <= wake_cnt_r + 4'h1;
      end
      awake_r <= wake_cnt_r >= WAKE_CYCLES - 4'h1;
    end
  end

  assign conv_start    = conv_start_r;
  assign conv_channel  = conv_channel_r;
  assign powered       = powered_r;
  assign awake         = awake_r;
  assign range_single  = ctrl_r.range_single;
  assign coding_binary = ctrl_r.coding_binary;
  assign seq_mode      = mode_r;

  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_normal_power: assert property (
    ctrl_load && new_ctrl.power_mode == PWR_NORMAL |=> powered_r)
    else $error("normal mode did not power up");

  a_shutdown_stays: assert property (
    ctrl_r.power_mode == PWR_SHUTDOWN |-> !powered_r)
    else $error("powered while in full shutdown");

  a_auto_sleep: assert property (
    ctrl_load && new_ctrl.power_mode == PWR_AUTO |=> !powered_r)
    else $error("auto mode did not shut down after update");

  a_wake_delay: assert property (
    $rose(powered_r) |-> (!awake_r)[*8] ##1 !awake_r ##1 !awake_r
                         ##1 (awake_r || !powered_r))
    else $error("wake-up interval not ten cycles");

  a_manual_chan: assert property (
    ctrl_load && new_seq_bits == 2'b00
    |=> next_chan_r == $past(new_ctrl.channel_addr)
        && mode_r == SEQ_MANUAL)
    else $error("manual channel not taken from address bits");

  a_mask_arm: assert property (
    ctrl_load && new_seq_bits == 2'b01 |=> mask_pending_r)
    else $error("mask load not armed");

  a_mask_guard: assert property (
    frame_done && !mask_pending_r |=> $stable(mask_r))
    else $error("mask written without arming");

  a_conv_chan: assert property (
    cs_fall |=> conv_start_r && conv_channel_r == $past(next_chan_r))
    else $error("conversion channel mismatch");

  a_keep_seq: assert property (
    ctrl_load && new_seq_bits == 2'b10 && mode_r != SEQ_MANUAL
    |=> $stable(mode_r) && $stable(next_chan_r))
    else $error("keeping write disturbed the sequence");

  a_consec_wrap: assert property (
    cs_fall && !frame_done && mode_r == SEQ_CONSEC
    && next_chan_r == final_chan_r |=> next_chan_r == CHAN_RESET)
    else $error("consecutive sequence did not wrap to zero");

  a_masked_slot: assert property (
    cs_fall && !frame_done && mode_r == SEQ_MASKED && mask_r != 16'h0000
    |=> mask_r[~slot_r] && next_chan_r == slot_r[2:0])
    else $error("sequencer landed on an unselected slot");

  a_exit_seq: assert property (
    ctrl_load && new_seq_bits == 2'b00 |=> mode_r == SEQ_MANUAL)
    else $error("sequencing not left on cleared bits");

  c_mask_load: cover property (mask_load ##[1:100] cs_fall);
  c_consec_wrap: cover property (
    cs_fall && mode_r == SEQ_CONSEC && next_chan_r == final_chan_r);
  c_auto_wake: cover property ($rose(powered_r) ##10 awake_r);

endmodule : adc_seq_ctrl

/* src/adc_seq_pkg.sv */
// Shared constants, field layouts and types of the converter control logic
package adc_seq_pkg;

  // Serial frame layout: first bit on the wire is bit 15
  localparam int FRAME_BITS      = 16;
  localparam int FRAME_WRITE_BIT = 15;
  localparam int CTRL_BITS       = 11;
  localparam int CTRL_LSB        = 4;
  localparam logic [4:0] FRAME_LAST_EDGE = 5'h0F;
  localparam logic [4:0] FRAME_EDGES     = 5'h10;

  // Control word field positions
  localparam int CB_SEQ_ENABLE = 10;
  localparam int CB_ADDR_HI    = 8;
  localparam int CB_ADDR_LO    = 6;
  localparam int CB_POWER_HI   = 5;
  localparam int CB_POWER_LO   = 4;
  localparam int CB_REG_SELECT = 3;
  localparam int CB_RANGE      = 1;
  localparam int CB_CODING     = 0;

  // Reset values: normal power, channel 0, sequencer unused
  localparam logic [10:0] CTRL_RESET = 11'h030;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [2:0]  CHAN_RESET = 3'h0;
  localparam logic [3:0]  SLOT_LAST  = 4'hF;

  // Wake-up interval after full shutdown
  localparam int WAKE_TIME_NS  = 1000;
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [3:0] WAKE_CYCLES =
    4'((WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    SEQ_MANUAL = 2'b00,
    SEQ_MASKED = 2'b01,
    SEQ_CONSEC = 2'b10
  } seq_mode_type;

  typedef enum logic [1:0] {
    PWR_INVALID  = 2'b00,
    PWR_AUTO     = 2'b01,
    PWR_SHUTDOWN = 2'b10,
    PWR_NORMAL   = 2'b11
  } power_mode_type;

  typedef struct packed {
    logic           sequence_enable;
    logic           spare_hi;
    logic [2:0]     channel_addr;
    power_mode_type power_mode;
    logic           reg_select;
    logic           spare_lo;
    logic           range_single;
    logic           coding_binary;
  } ctrl_word_type;

endpackage : adc_seq_pkg

/* src/serial_frame_rx.sv */
// Serial-clock domain receiver: shifts one 16-bit frame per chip select
`timescale 1ns/1ps
module serial_frame_rx
  import adc_seq_pkg::*;
(
  input  wire logic        sclk,         // Serial clock from the host
  input  wire logic        rst,          // Clears word and toggle
  input  wire logic        cs_n,         // Chip select, active low
  input  wire logic        din,          // Serial data in
  output logic [15:0]      frame_word,   // Last complete frame
  output logic             frame_toggle  // Flips once per complete frame
);

  logic [14:0] shift_r;
  logic [4:0]  edge_cnt_r;

  // Chip select high ends the frame; the clock may stop right after
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      edge_cnt_r <= 5'h00;
      shift_r    <= 15'h0000;
    end else if (edge_cnt_r != FRAME_EDGES) begin
      shift_r    <= {shift_r[13:0], din};
      edge_cnt_r <= edge_cnt_r + 5'h01;
    end
  end

  // The frame word is held until the next frame completes, which gives
  // the system side many serial clocks to sample it after the toggle
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      frame_word   <= 16'h0000;
      frame_toggle <= 1'b0;
    end else if (!cs_n && edge_cnt_r == FRAME_LAST_EDGE) begin
      frame_word   <= {shift_r, din};
      frame_toggle <= ~frame_toggle;
    end
  end

  a_edge_bound: assert property (
    @(negedge sclk) disable iff (cs_n)
    edge_cnt_r <= FRAME_EDGES)
    else $error("serial edge count ran past a frame");

endmodule : serial_frame_rx

/* testbench/host_model.sv */
// Host-side model: sends one serial frame per chip-select low period
`timescale 1ns/1ps
module host_model (
  input  wire logic clk_sys, // Paces chip-select changes
  output logic      sclk,    // Serial clock, still between frames
  output logic      cs_n,    // Chip select, active low
  output logic      din      // Serial data, first bit is bit 15
);
  initial begin
    sclk = 1'h1;
    cs_n = 1'h1;
    din  = 1'h0;
  end

  task automatic send_frame(input logic [15:0] word);
    @(posedge clk_sys);
    cs_n <= 1'h0;
    repeat (5) @(posedge clk_sys);
    for (int k = 0; k < 16; k++) begin
      din = word[15-k];
      #6 sclk = 1'h0;
      #6 sclk = 1'h1;
    end
    // Released line shows the inverse so a stale bit cannot pass as data
    din = ~din;
    repeat (6) @(posedge clk_sys);
    cs_n <= 1'h1;
    // Long high time covers the wake-up interval before the next frame
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : send_frame
endmodule : host_model

/* testbench/tb_top.sv */
// Self-checking bench of the converter power and sequencer control
`timescale 1ns/1ps
module tb_top
  import adc_seq_pkg::*;
;
  localparam int TIMEOUT = 3000;
  logic       clk_sys;
  logic       rst;
  logic       sclk;
  logic       cs_n;
  logic       din;
  logic       conv_start;
  logic [2:0] conv_channel;
  logic       powered;
  logic       awake;
  logic       range_single;
  logic       coding_binary;
  logic [1:0] seq_mode;
  logic [2:0] conv_q[$];
  int         n_mismatch = 0;
  int         checked = 0;
  int         cycles = 0;
  int         wake_cnt = 0;
  int         wake_len = 0;

  adc_seq_ctrl dut (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .sclk         (sclk),
    .cs_n         (cs_n),
    .din          (din),
    .conv_start   (conv_start),
    .conv_channel (conv_channel),
    .powered      (powered),
    .awake        (awake),
    .range_single (range_single),
    .coding_binary(coding_binary),
    .seq_mode     (seq_mode)
  );

  host_model host (
    .clk_sys(clk_sys),
    .sclk   (sclk),
    .cs_n   (cs_n),
    .din    (din)
  );

  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Records each started channel and the length of each wake-up; sampled
  // on the falling edge, where the registered outputs have settled
  always @(negedge clk_sys) begin
    cycles <= cycles + 1;
    if (conv_start === 1'h1) begin
      conv_q.push_back(conv_channel);
    end
    if (powered === 1'h1 && awake === 1'h0) begin
      wake_cnt <= wake_cnt + 1;
    end else if (wake_cnt != 0) begin
      wake_len <= wake_cnt;
      wake_cnt <= 0;
    end
    if (cycles == TIMEOUT) begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end

  function automatic logic [15:0] ctl(input logic sq, input logic sel,
    input logic [2:0] addr, input logic [1:0] pm, input logic rng);
    return {1'h1, sq, 1'h0, addr, pm, sel, 1'h0, rng, 1'h1, 4'h0};
  endfunction : ctl

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic check_chans(input logic [2:0] exp[7], input int n);
    for (int i = 0; i < n; i++) begin
      check(16'(conv_q[i]), 16'(exp[i]));
    end
  endtask : check_chans

  // Frames with the write bit clear; their other bits must change nothing
  task automatic idle_frames(input int n);
    for (int i = 0; i < n; i++) begin
      host.send_frame(16'h7FFF ^ 16'(i * 16'h1111));
    end
  endtask : idle_frames

  task automatic t_reset();
    check({conv_channel, powered, awake, range_single, coding_binary,
           seq_mode}, {3'h0, 1'h1, 1'h1, 1'h0, 1'h0, 2'h0});
  endtask : t_reset

  task automatic t_manual();
    conv_q.delete();
    host.send_frame(ctl(1'h0, 1'h0, 3'h5, 2'h3, 1'h1));
    check({range_single, coding_binary}, 2'h3);
    host.send_frame(16'h7FFF);
    check({range_single, coding_binary, seq_mode}, 4'hC);
    check(16'(conv_q[0]), 16'h0);
    check(16'(conv_q[1]), 16'h5);
  endtask : t_manual

  task automatic t_masked();
    logic [2:0] exp[7] = '{3'h1, 3'h4, 3'h2, 3'h1, 3'h4, 3'h2, 3'h3};
    // Mask-shaped frame without arming must not start a sequence
    host.send_frame(16'h4820);
    check(16'(seq_mode), 16'h0);
    host.send_frame(ctl(1'h0, 1'h1, 3'h0, 2'h3, 1'h0));
    // Sequence one: channels 1 and 4; sequence two: channel 2
    host.send_frame(16'h4820);
    conv_q.delete();
    idle_frames(3);
    host.send_frame(ctl(1'h1, 1'h0, 3'h0, 2'h3, 1'h1));
    check({range_single, seq_mode}, 3'h5);
    idle_frames(1);
    host.send_frame(ctl(1'h0, 1'h0, 3'h3, 2'h3, 1'h0));
    idle_frames(1);
    check(16'(seq_mode), 16'h0);
    check_chans(exp, 7);
  endtask : t_masked

  task automatic t_consec();
    logic [2:0] exp[7] = '{3'h3, 3'h0, 3'h1, 3'h2, 3'h0, 3'h1, 3'h0};
    conv_q.delete();
    host.send_frame(ctl(1'h1, 1'h1, 3'h2, 2'h3, 1'h0));
    check(16'(seq_mode), 16'h2);
    idle_frames(4);
    host.send_frame(ctl(1'h0, 1'h0, 3'h0, 2'h3, 1'h0));
    check(16'(seq_mode), 16'h0);
    check_chans(exp, 6);
  endtask : t_consec

  task automatic t_power();
    host.send_frame(ctl(1'h0, 1'h0, 3'h0, 2'h2, 1'h0));
    check(16'(powered), 16'h0);
    idle_frames(2);
    check(16'(powered), 16'h0);
    host.send_frame(ctl(1'h0, 1'h0, 3'h0, 2'h3, 1'h0));
    check(16'(powered), 16'h1);
    host.send_frame(ctl(1'h0, 1'h0, 3'h0, 2'h1, 1'h0));
    check(16'(powered), 16'h0);
    idle_frames(1);
    check({powered, awake}, 2'h3);
    check(16'(wake_len), 16'(WAKE_CYCLES));
    host.send_frame(ctl(1'h0, 1'h0, 3'h0, 2'h3, 1'h0));
    check(16'(powered), 16'h1);
  endtask : t_power

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  initial begin
    rst = 1'h1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    @(negedge clk_sys);
    t_reset();
    t_manual();
    t_masked();
    t_consec();
    t_power();
    summarize();
  end
endmodule : tb_top
